// *** common/dlreg_pkg.sv ***
/*
  Package for the link control, GPIO and error register bank:
  register indices, field positions, reset values and timing counts.
  Assumes a 200 MHz core clock and an APB slave with 32-bit data.
*/
`default_nettype none
package dlreg_pkg;
  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_I2C_BRIDGE_CONFIG    = 8'h0D;
  localparam logic [7:0] IDX_GPIO_CONTROL_STATUS  = 8'h0E;
  localparam logic [7:0] IDX_DETECTED_THRESHOLD   = 8'h0F;
  localparam logic [7:0] IDX_DETECTED_COUNT       = 8'h10;
  localparam logic [7:0] IDX_CORRECTED_THRESHOLD  = 8'h11;
  localparam logic [7:0] IDX_CORRECTED_COUNT      = 8'h12;
  localparam logic [7:0] IDX_TEST_PATTERN_COUNT   = 8'h13;
  localparam logic [7:0] IDX_ERROR_CONTROL        = 8'h08;
  localparam logic [7:0] IDX_LINK_STATUS          = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_LOCAL_ACK_BIT   = 7;
  localparam int CFG_SETUP_HOLD_LSB  = 5;
  localparam int CFG_BITRATE_LSB     = 2;
  localparam int CFG_TIMEOUT_LSB     = 0;
  localparam int GP_FORWARD_BIT      = 5;
  localparam int GP_INPUT_BIT        = 4;
  localparam int GP_PIN1_OUT_BIT     = 3;
  localparam int GP_PIN1_IN_BIT      = 2;
  localparam int GP_PIN0_OUT_BIT     = 1;
  localparam int GP_PIN0_IN_BIT      = 0;
  localparam int EC_AUTO_CLEAR_BIT   = 2;
  localparam int EC_SELECT_LSB       = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_I2C_BRIDGE_CONFIG = 8'h36;
  localparam logic [1:0] GP_RESERVED_VALUE     = 2'h1;
  localparam logic       RST_FORWARD_ENABLE    = 1'b1;
  localparam logic       RST_PIN_DRIVE         = 1'b1;
  localparam logic [7:0] RST_BYTE              = 8'h00;
  localparam logic [1:0] RST_ERROR_SELECT      = 2'h0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_DETECTED   = 2'h0;
  localparam logic [1:0] SEL_CORRECTED  = 2'h1;
  localparam logic [1:0] TIMEOUT_OFF    = 2'h3;
  localparam logic [7:0] COUNT_MAX      = 8'hFF;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ      = 200;
  localparam int AUTO_CLEAR_NS     = 1000;
  localparam int AUTO_CLEAR_CYCLES =
    (AUTO_CLEAR_NS * CLK_FREQ_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    DLREG_IDLE  = 2'b00,
    DLREG_WAIT  = 2'b01,
    DLREG_CLEAR = 2'b10
  } dlreg_clr_state_t;
endpackage : dlreg_pkg
`default_nettype wire

// *** rtl/dlreg_bank.sv ***
/*
  Register bank of a serial-link deserializer: I2C bridge setup,
  GPIO with readback, input forwarding and error threshold/counters.
  Assumes an APB master on core_clk and synchronous pin inputs.
*/
// Register access over APB was chosen for this implementation.
// Functional notes
// - local-ack bit 7 set makes bridge ack locally when forward path down.
// - two-bit setup/hold select, four settings, resets to 01.
// - three-bit master bit-rate select, eight rates, resets to 101.
// - two-bit remote timeout select, 11 disables timeout, resets to 10.
// - forward-enable bit 5 passes general input to serializer; resets 1.
// - GPIO pins drive output bits (reset 1); bits 4,2,0 read pin levels.
// - read-only detected counter and writable detected threshold, reset 0.
// - read-only corrected counter and writable corrected threshold, reset 0.
// - error output select: detected, corrected, or either above threshold.
// - auto clear wipes both counters 1 us after error output asserts.
`default_nettype none
module dlreg_bank
  import dlreg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // link events
  input  wire logic        detected_error_pulse,
  input  wire logic        corrected_error_pulse,
  input  wire logic        checker_running,
  input  wire logic        test_pattern_bit_error,
  input  wire logic        forward_channel_up,
  // pins
  input  wire logic        general_input_level,
  input  wire logic        pin0_in,
  input  wire logic        pin1_in,
  output logic             pin0_out,
  output logic             pin0_oe_n,
  output logic             pin1_out,
  output logic             pin1_oe_n,
  // bridge settings and status out
  output logic             bridge_local_ack,
  output logic [1:0]       slave_setup_hold_sel,
  output logic [2:0]       master_bitrate_sel,
  output logic [1:0]       slave_remote_timeout_sel,
  output logic             slave_timeout_enable,
  output logic             forward_input_level,
  output logic             error_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       bridge_cfg;
    logic             input_forward_enable;
    logic             pin1_drive_level;
    logic             pin0_drive_level;
    logic [7:0]       detected_threshold;
    logic [7:0]       detected_count;
    logic [7:0]       corrected_threshold;
    logic [7:0]       corrected_count;
    logic [7:0]       test_pattern_error_count;
    logic [1:0]       error_output_select;
    logic             auto_clear_counters;
    dlreg_clr_state_t clr_state;
    logic [7:0]       clr_timer;
    logic             ready;
    logic [31:0]      rdata;
    logic             slverr;
    logic             err;
    logic             fwd;
    logic             local_ack;
    logic             tmo_en;
  } dlreg_state_t;

  dlreg_state_t cur;
  dlreg_state_t next_cur;

  logic [7:0] idx;
  logic       word_ok;
  logic       det_over;
  logic       cor_over;
  logic       err_cond;
  logic [7:0] rd_byte;
  logic       hit;

  assign idx     = paddr[9:2];
  assign word_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign det_over = cur.detected_count > cur.detected_threshold;
  assign cor_over = cur.corrected_count > cur.corrected_threshold;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = RST_BYTE;
    hit     = word_ok;
    case (idx)
      IDX_I2C_BRIDGE_CONFIG:   rd_byte = cur.bridge_cfg;
      IDX_GPIO_CONTROL_STATUS: rd_byte = {GP_RESERVED_VALUE,
        cur.input_forward_enable, general_input_level,
        cur.pin1_drive_level, pin1_in,
        cur.pin0_drive_level, pin0_in};
      IDX_DETECTED_THRESHOLD:  rd_byte = cur.detected_threshold;
      IDX_DETECTED_COUNT:      rd_byte = cur.detected_count;
      IDX_CORRECTED_THRESHOLD: rd_byte = cur.corrected_threshold;
      IDX_CORRECTED_COUNT:     rd_byte = cur.corrected_count;
      IDX_TEST_PATTERN_COUNT:  rd_byte = cur.test_pattern_error_count;
      IDX_ERROR_CONTROL:       rd_byte = {5'h00, cur.auto_clear_counters,
                                          cur.error_output_select};
      IDX_LINK_STATUS:         rd_byte = {6'h00, forward_channel_up,
                                          cur.err};
      default:                 hit     = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic wr;
    logic access;
    wr       = 1'b0;
    access   = 1'b0;
    err_cond = 1'b0;
    next_cur = cur;

    // one wait state: answer lands on the second access cycle
    access = psel && penable && !cur.ready;
    next_cur.ready  = access;
    next_cur.slverr = access && !hit;
    next_cur.rdata  = (access && !pwrite && hit) ? {24'h000000, rd_byte}
                                                 : 32'h00000000;
    wr = access && pwrite && hit && pstrb[0];

    // event counters, saturating so a burst cannot wrap below threshold
    if (detected_error_pulse && cur.detected_count != COUNT_MAX) begin
      next_cur.detected_count = cur.detected_count + 8'h01;
    end
    if (corrected_error_pulse && cur.corrected_count != COUNT_MAX) begin
      next_cur.corrected_count = cur.corrected_count + 8'h01;
    end
    if (checker_running && test_pattern_bit_error &&
        cur.test_pattern_error_count != COUNT_MAX) begin
      next_cur.test_pattern_error_count =
        cur.test_pattern_error_count + 8'h01;
    end

    // software writes; read-only bits are never written
    if (wr) begin
      case (idx)
        IDX_I2C_BRIDGE_CONFIG: next_cur.bridge_cfg = pwdata[7:0];
        IDX_GPIO_CONTROL_STATUS: begin
          next_cur.input_forward_enable = pwdata[GP_FORWARD_BIT];
          next_cur.pin1_drive_level     = pwdata[GP_PIN1_OUT_BIT];
          next_cur.pin0_drive_level     = pwdata[GP_PIN0_OUT_BIT];
        end
        IDX_DETECTED_THRESHOLD:  next_cur.detected_threshold  = pwdata[7:0];
        IDX_CORRECTED_THRESHOLD: next_cur.corrected_threshold = pwdata[7:0];
        IDX_ERROR_CONTROL: begin
          next_cur.error_output_select =
            pwdata[EC_SELECT_LSB +: 2];
          next_cur.auto_clear_counters = pwdata[EC_AUTO_CLEAR_BIT];
        end
        default: ;
      endcase
    end

    // error output select
    case (cur.error_output_select)
      SEL_DETECTED:  err_cond = det_over;
      SEL_CORRECTED: err_cond = cor_over;
      default:       err_cond = det_over || cor_over;
    endcase
    next_cur.err = err_cond;

    // auto clear: timer starts on the rising edge of the error output
    case (cur.clr_state)
      DLREG_IDLE: begin
        if (cur.auto_clear_counters && err_cond && !cur.err) begin
          next_cur.clr_state = DLREG_WAIT;
          next_cur.clr_timer = 8'(AUTO_CLEAR_CYCLES - 2);
        end
      end
      DLREG_WAIT: begin
        if (cur.clr_timer == 8'h00) begin
          next_cur.clr_state = DLREG_CLEAR;
        end else begin
          next_cur.clr_timer = cur.clr_timer - 8'h01;
        end
      end
      DLREG_CLEAR: begin
        next_cur.detected_count  = RST_BYTE;
        next_cur.corrected_count = RST_BYTE;
        next_cur.clr_state       = DLREG_IDLE;
      end
      default: next_cur.clr_state = DLREG_IDLE;
    endcase

    next_cur.fwd       = cur.input_forward_enable &&
                         general_input_level;
    next_cur.local_ack = cur.bridge_cfg[CFG_LOCAL_ACK_BIT] &&
                         !forward_channel_up;
    // registered copy so the enable follows the field in the same cycle
    next_cur.tmo_en    =
      next_cur.bridge_cfg[CFG_TIMEOUT_LSB +: 2] != TIMEOUT_OFF;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur                          <= '0;
      cur.bridge_cfg <= RST_I2C_BRIDGE_CONFIG;
      cur.tmo_en     <= RST_I2C_BRIDGE_CONFIG[CFG_TIMEOUT_LSB +: 2] !=
                        TIMEOUT_OFF;
      cur.input_forward_enable     <= RST_FORWARD_ENABLE;
      cur.pin1_drive_level         <= RST_PIN_DRIVE;
      cur.pin0_drive_level         <= RST_PIN_DRIVE;
      cur.error_output_select      <= RST_ERROR_SELECT;
      cur.clr_state                <= DLREG_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // outputs, straight from flops except the tied-low pin output enables
  // ---------------------------------------------------------------
  assign pready   = cur.ready;
  assign prdata   = cur.rdata;
  assign pslverr  = cur.slverr;
  assign pin0_out = cur.pin0_drive_level;
  assign pin1_out = cur.pin1_drive_level;
  assign pin0_oe_n = 1'b0;
  assign pin1_oe_n = 1'b0;
  assign bridge_local_ack     = cur.local_ack;
  assign slave_setup_hold_sel =
    cur.bridge_cfg[CFG_SETUP_HOLD_LSB +: 2];
  assign master_bitrate_sel   =
    cur.bridge_cfg[CFG_BITRATE_LSB +: 3];
  assign slave_remote_timeout_sel = cur.bridge_cfg[CFG_TIMEOUT_LSB +: 2];
  assign slave_timeout_enable = cur.tmo_en;
  assign forward_input_level  = cur.fwd;
  assign error_out            = cur.err;

endmodule : dlreg_bank // dlreg_bank
`default_nettype wire

// *** tb/dlreg_checker.sv ***
/*
  Port-level assertions for the register bank.
  Assumes binding onto every dlreg_bank instance, one clock domain.
*/
`default_nettype none
module dlreg_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // link and pins
  input wire logic        forward_channel_up,
  input wire logic        general_input_level,
  input wire logic        bridge_local_ack,
  input wire logic [1:0]  slave_remote_timeout_sel,
  input wire logic        slave_timeout_enable,
  input wire logic        forward_input_level,
  input wire logic        pin0_out,
  input wire logic        pin0_oe_n,
  input wire logic        pin1_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_ONE_WAIT:
    assert property (psel && penable && !pready |=> pready) else $error("no answer");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("long ready");
  AST_IDLE_DATA:
    assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  AST_UPPER_ZERO:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  AST_LOCAL_ACK:
    assert property (bridge_local_ack |-> !$past(forward_channel_up))
      else $error("ack with channel up");
  AST_TIMEOUT_OFF:
    assert property (slave_timeout_enable == (slave_remote_timeout_sel != 2'h3))
      else $error("timeout enable");
  AST_FORWARD:
    assert property (forward_input_level |-> $past(general_input_level))
      else $error("forward level");
  AST_DRIVEN:
    assert property (!pin0_oe_n && !pin1_oe_n) else $error("pin released");
  AST_PIN_WRITE:
    assert property ($changed(pin0_out) |-> $past(psel && pwrite))
      else $error("pin moved");
endmodule // dlreg_checker

bind dlreg_bank dlreg_checker chk (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .prdata(prdata), .forward_channel_up(forward_channel_up),
  .general_input_level(general_input_level),
  .bridge_local_ack(bridge_local_ack),
  .slave_remote_timeout_sel(slave_remote_timeout_sel),
  .slave_timeout_enable(slave_timeout_enable),
  .forward_input_level(forward_input_level), .pin0_out(pin0_out),
  .pin0_oe_n(pin0_oe_n), .pin1_oe_n(pin1_oe_n));
`default_nettype wire

// *** tb/dlreg_host.sv ***
/*
  Host model: APB master reaching the register bank.
  Assumes callers invoke xfer right after a rising edge.
*/
`default_nettype none
module dlreg_host (
  // clock
  input wire logic         core_clk,
  // apb
  output var logic         psel,
  output var logic         penable,
  output var logic         pwrite,
  output var logic [11:0]  paddr,
  output var logic [31:0]  pwdata,
  output var logic [3:0]   pstrb,
  input wire logic         pready,
  input wire logic [31:0]  prdata,
  input wire logic         pslverr
);
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hF;
  end
  // one idle edge first, so a release never meets the next setup
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // no cycle count assumed: only the bench watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule // dlreg_host
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the register bank.
  Assumes the host model and checker files compile before it.
*/
`default_nettype none
module testbench;
  import dlreg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, det = 0, cor = 0, run = 0, tpe = 0;
  logic fwd_up = 1, gen = 0, p0 = 0, p1 = 1;
  logic psel, penable, pwrite, pready, pslverr, p0o, p1o, lack, tmo_en;
  logic fwd_lvl, err_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [1:0] sh, tmo;
  logic [2:0] rate;
  logic e;
  int n_mismatch = 0, tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  dlreg_host host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr);
  dlreg_bank dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .detected_error_pulse(det), .corrected_error_pulse(cor),
    .checker_running(run), .test_pattern_bit_error(tpe),
    .forward_channel_up(fwd_up), .general_input_level(gen), .pin0_in(p0),
    .pin1_in(p1), .pin0_out(p0o), .pin0_oe_n(), .pin1_out(p1o),
    .pin1_oe_n(), .bridge_local_ack(lack), .slave_setup_hold_sel(sh),
    .master_bitrate_sel(rate), .slave_remote_timeout_sel(tmo),
    .slave_timeout_enable(tmo_en), .forward_input_level(fwd_lvl),
    .error_out(err_out));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    host.xfer(0, a, 32'h0, q, e);
    chk(q, {24'h0, d});
  endtask
  // m picks the event inputs: bit2 detected, bit1 corrected, bit0 pattern
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) @(posedge core_clk) {det, cor, tpe} <= m;
    @(posedge core_clk) {det, cor, tpe} <= 3'h0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic t_reset();
    rd(12'h034, 8'h36);
    rd(12'h038, 8'h6E);
    chk({sh, rate, tmo, p0o, p1o}, {2'h1, 3'h5, 2'h2, 2'h3});
    rd(12'h03C, 8'h00);
    rd(12'h040, 8'h00);
    rd(12'h044, 8'h00);
    rd(12'h048, 8'h00);
    rd(12'h04C, 8'h00);
  endtask
  task automatic t_config();
    logic [7:0] v;
    fwd_up <= 0;
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[1:0], i[2:0], i[1:0]};
      wr(12'h034, v);
      rd(12'h034, v);
      chk({sh, rate, tmo, tmo_en, lack}, {v[6:0], i[1:0] != 2'h3, i[0]});
    end
    fwd_up <= 1;
    repeat (2) @(posedge core_clk);
    chk(lack, 0);
  endtask
  task automatic t_gpio();
    gen <= 1; p1 <= 0; p0 <= 1;
    wr(12'h038, 8'h00);
    rd(12'h038, 8'h51);
    chk({p1o, p0o, fwd_lvl}, 0);
    wr(12'h038, 8'hFF);
    rd(12'h038, 8'h7B);
    chk({p1o, p0o, fwd_lvl}, 3'h7);
    gen <= 0;
    repeat (2) @(posedge core_clk);
    chk(fwd_lvl, 0);
  endtask
  task automatic t_errors();
    wr(12'h03C, 8'h02);
    rd(12'h03C, 8'h02);
    wr(12'h020, 8'h04);
    pulse(3'h4, 2);
    chk(err_out, 0);
    pulse(3'h4, 1);
    chk(err_out, 1);
    rd(12'h040, 8'h03);
    // clear lands 200 cycles after the rise; read just before and after
    repeat (185) @(posedge core_clk);
    rd(12'h040, 8'h03);
    repeat (10) @(posedge core_clk);
    rd(12'h040, 8'h00);
    chk(err_out, 0);
    wr(12'h020, 8'h01);
    wr(12'h044, 8'h01);
    pulse(3'h2, 2);
    chk(err_out, 1);
    repeat (250) @(posedge core_clk);
    wr(12'h048, 8'h00);
    rd(12'h048, 8'h02);
    wr(12'h020, 8'h00);
    repeat (2) @(posedge core_clk);
    chk(err_out, 0);
    wr(12'h020, 8'h02);
    repeat (2) @(posedge core_clk);
    chk(err_out, 1);
  endtask
  task automatic t_pattern();
    pulse(3'h1, 2);
    rd(12'h04C, 8'h00);
    run <= 1;
    pulse(3'h1, 3);
    rd(12'h04C, 8'h03);
    pulse(3'h1, 300);
    rd(12'h04C, 8'hFF);
    host.xfer(0, 12'h000, 32'h0, q, e);
    chk(q, 0);
    chk(e, 1);
    host.xfer(0, 12'h035, 32'h0, q, e);
    chk(e, 1);
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    t_reset();
    t_config();
    t_gpio();
    t_errors();
    t_pattern();
    summarize();
  end
endmodule // testbench
`default_nettype wire
